//--- core/acm_pkg.sv
// package: constants, types and mode codes for the accelerometer mode/format block
// assumes one 125 MHz clock and an outside register file that holds the control bits
package acm_pkg;

  localparam int CLK_MHZ = 125;
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_DIV_CYC = 1000;
  localparam int SLEEP_DIV_CYC = 4000;

  localparam logic [7:0] ADDR_X_HI = 8'h00;
  localparam logic [7:0] ADDR_X_LO = 8'h01;
  localparam logic [7:0] ADDR_Y_HI = 8'h02;
  localparam logic [7:0] ADDR_Y_LO = 8'h03;
  localparam logic [7:0] ADDR_Z_HI = 8'h04;
  localparam logic [7:0] ADDR_Z_LO = 8'h05;

  localparam int AXIS_W = 12;
  localparam int RAW_W = 14;
  localparam logic signed [AXIS_W-1:0] AXIS_MAX = 12'sh7FF;
  localparam logic signed [AXIS_W-1:0] AXIS_MIN = -12'sh800;
  localparam logic [AXIS_W-1:0] AXIS_RST = 12'h000;
  localparam logic signed [RAW_W-1:0] STIM_X = 14'sh00B4;
  localparam logic signed [RAW_W-1:0] STIM_Y = 14'sh00B4;
  localparam logic signed [RAW_W-1:0] STIM_Z = 14'sh0168;

  typedef enum logic [1:0] {
    ACM_OFF = 2'b00,
    ACM_STANDBY = 2'b01,
    ACM_ACTIVE = 2'b10
  } acm_mode_t;

  typedef enum logic [1:0] {
    ACM_RANGE_2G = 2'b00,
    ACM_RANGE_4G = 2'b01,
    ACM_RANGE_8G = 2'b10
  } acm_range_t;

  typedef struct packed {
    logic signed [RAW_W-1:0] x;
    logic signed [RAW_W-1:0] y;
    logic signed [RAW_W-1:0] z;
  } acm_raw_t;

  typedef struct packed {
    logic [7:0] x_hi;
    logic [7:0] x_lo;
    logic [7:0] y_hi;
    logic [7:0] y_lo;
    logic [7:0] z_hi;
    logic [7:0] z_lo;
  } acm_out_t;

  typedef struct packed {
    logic digital_en;
    logic analog_en;
    logic bus_en;
    logic sleeping;
  } acm_pwr_t;

endpackage

//--- core/acm_glitch_filter.sv
// glitch filter for one bus line: three-flop sync then a stability count
// assumes the pin is asynchronous to CLK
`timescale 1ns/100ps
module acm_glitch_filter
  import acm_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PIN,
  output logic FILT
);

  logic s1_q, s2_q, s3_q;
  logic [3:0] cnt_q;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= PIN;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level must hold longer than the spike width before it passes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_q <= 4'h0;
      FILT <= 1'b1;
    end else if (s2_q != s3_q || s3_q == FILT) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == 4'(GLITCH_CYC - 1)) begin
      cnt_q <= 4'h0;
      FILT <= s3_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

endmodule

//--- core/acm_mode_format.sv
// mode sequencer and sample formatter for a three-axis accelerometer
// assumes the register file and bus slave sit outside and feed same-clock control bits
`timescale 1ns/100ps
module acm_mode_format
  import acm_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic POWER_GOOD,
  input wire logic SCL_PIN,
  input wire logic SDA_PIN,
  input wire logic ACTIVE_BIT,
  input wire logic CFG_WR_DONE,
  input wire logic [1:0] RANGE_SEL,
  input wire logic SELF_TEST_EN,
  input wire logic SLEEP_REQ,
  input wire acm_raw_t RAW_ACCEL,
  output logic SCL_FILT,
  output logic SDA_FILT,
  output acm_mode_t MODE,
  output acm_pwr_t PWR,
  output logic SAMPLE_TICK,
  output logic CLEAR_MARKED,
  output acm_out_t OUT_REGS,
  output logic DATA_READY
);

  logic pg1_q, pg2_q, pg3_q, pg_q;
  logic scl_f, sda_f;
  logic [11:0] div_q;
  logic [11:0] div_end;
  acm_raw_t raw_st;
  logic [AXIS_W-1:0] x_s, y_s, z_s;

  // scale a raw value held at 1024 counts/g to the selected range, then clamp
  function automatic logic [AXIS_W-1:0] scale_axis(input logic signed [RAW_W-1:0] v,
                                                   input logic [1:0] rng);
    logic signed [RAW_W-1:0] s;
    s = v;
    case (rng)
      ACM_RANGE_4G: s = v >>> 1;
      ACM_RANGE_8G: s = v >>> 2;
      default: s = v;
    endcase
    if (s > RAW_W'(AXIS_MAX)) begin
      scale_axis = AXIS_MAX;
    end else if (s < RAW_W'(AXIS_MIN)) begin
      scale_axis = AXIS_MIN;
    end else begin
      scale_axis = s[AXIS_W-1:0];
    end
  endfunction

  // supply-good level from the pin: three flops, change taken when 2 and 3 agree
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pg1_q <= 1'b0;
      pg2_q <= 1'b0;
      pg3_q <= 1'b0;
      pg_q <= 1'b0;
    end else begin
      pg1_q <= POWER_GOOD;
      pg2_q <= pg1_q;
      pg3_q <= pg2_q;
      if (pg2_q == pg3_q) begin
        pg_q <= pg3_q;
      end
    end
  end

  // both lines share one filter design
  acm_glitch_filter u_scl_filt (
    .CLK(CLK),
    .RSTN(RSTN),
    .PIN(SCL_PIN),
    .FILT(scl_f)
  );

  acm_glitch_filter u_sda_filt (
    .CLK(CLK),
    .RSTN(RSTN),
    .PIN(SDA_PIN),
    .FILT(sda_f)
  );

  // filtered lines reach the bus logic only while it is powered
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SCL_FILT <= 1'b1;
      SDA_FILT <= 1'b1;
    end else if (MODE == ACM_OFF) begin
      SCL_FILT <= 1'b1;
      SDA_FILT <= 1'b1;
    end else begin
      SCL_FILT <= scl_f;
      SDA_FILT <= sda_f;
    end
  end

  // mode changes between standby and active only when a register write has completed
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MODE <= ACM_OFF;
    end else if (!pg_q) begin
      MODE <= ACM_OFF;
    end else begin
      case (MODE)
        ACM_OFF: MODE <= ACM_STANDBY;
        ACM_STANDBY: begin
          if (CFG_WR_DONE && ACTIVE_BIT) begin
            MODE <= ACM_ACTIVE;
          end
        end
        ACM_ACTIVE: begin
          if (CFG_WR_DONE && !ACTIVE_BIT) begin
            MODE <= ACM_STANDBY;
          end
        end
        default: MODE <= ACM_OFF;
      endcase
    end
  end

  // clear pulse for marked registers on entry to active only
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CLEAR_MARKED <= 1'b0;
    end else begin
      CLEAR_MARKED <= pg_q && MODE == ACM_STANDBY && CFG_WR_DONE && ACTIVE_BIT;
    end
  end

  // power enables per mode; sleep is a flavour of active, not a mode of its own
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PWR <= '0;
    end else begin
      case (MODE)
        ACM_STANDBY: PWR <= '{digital_en: 1'b1, analog_en: 1'b0, bus_en: 1'b1, sleeping: 1'b0};
        ACM_ACTIVE: PWR <= '{digital_en: 1'b1, analog_en: 1'b1, bus_en: 1'b1, sleeping: SLEEP_REQ};
        default: PWR <= '0;
      endcase
    end
  end

  // sample clock divider runs in active only; sleep stretches the period
  assign div_end = (MODE == ACM_ACTIVE && SLEEP_REQ) ? 12'(SLEEP_DIV_CYC - 1) : 12'(WAKE_DIV_CYC - 1);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_q <= 12'h000;
      SAMPLE_TICK <= 1'b0;
    end else if (MODE != ACM_ACTIVE) begin
      div_q <= 12'h000;
      SAMPLE_TICK <= 1'b0;
    end else if (div_q >= div_end) begin
      div_q <= 12'h000;
      SAMPLE_TICK <= 1'b1;
    end else begin
      div_q <= div_q + 12'h001;
      SAMPLE_TICK <= 1'b0;
    end
  end

  // self-test stimulus is added before the range scaling
  always_comb begin
    raw_st = RAW_ACCEL;
    if (SELF_TEST_EN) begin
      raw_st.x = RAW_ACCEL.x + STIM_X;
      raw_st.y = RAW_ACCEL.y + STIM_Y;
      raw_st.z = RAW_ACCEL.z + STIM_Z;
    end
  end

  assign x_s = scale_axis(raw_st.x, RANGE_SEL);
  assign y_s = scale_axis(raw_st.y, RANGE_SEL);
  assign z_s = scale_axis(raw_st.z, RANGE_SEL);

  // output bytes are kept through standby and lost only when powered off
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      OUT_REGS <= '0;
      DATA_READY <= 1'b0;
    end else if (MODE == ACM_OFF) begin
      OUT_REGS <= '0;
      DATA_READY <= 1'b0;
    end else if (SAMPLE_TICK && MODE == ACM_ACTIVE) begin
      OUT_REGS <= '{x_hi: x_s[11:4], x_lo: {x_s[3:0], 4'h0},
                    y_hi: y_s[11:4], y_lo: {y_s[3:0], 4'h0},
                    z_hi: z_s[11:4], z_lo: {z_s[3:0], 4'h0}};
      DATA_READY <= 1'b1;
    end else begin
      DATA_READY <= 1'b0;
    end
  end

endmodule

//--- verification/acm_mode_format_assertions.sv
// checker: mode, power and sample timing at the ports
// assumes bind onto the mode/format block
`timescale 1ns/100ps
module acm_mode_format_chk
  import acm_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CFG_WR_DONE,
  input wire logic ACTIVE_BIT,
  input wire acm_mode_t MODE,
  input wire acm_pwr_t PWR,
  input wire logic SAMPLE_TICK,
  input wire logic CLEAR_MARKED,
  input wire acm_out_t OUT_REGS,
  input wire logic DATA_READY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // pwr lags mode by a cycle, so only settled modes are judged
  a_off_all_down: assert property (MODE == ACM_OFF && $past(MODE) == ACM_OFF |-> PWR == 4'h0)
    else $error("off pwr");
  a_stby_digital: assert property (MODE == ACM_STANDBY && $past(MODE) == ACM_STANDBY |-> PWR == 4'hA)
    else $error("stby pwr");
  a_tick_active: assert property (SAMPLE_TICK |-> MODE == ACM_ACTIVE)
    else $error("tick");
  a_act_all_on: assert property (MODE == ACM_ACTIVE && $past(MODE) == ACM_ACTIVE |-> PWR[3:1] == 3'h7)
    else $error("act pwr");
  a_go_active: assert property (CFG_WR_DONE && ACTIVE_BIT && MODE == ACM_STANDBY |=>
    MODE == ACM_ACTIVE && CLEAR_MARKED)
    else $error("to act");
  a_go_standby: assert property (CFG_WR_DONE && !ACTIVE_BIT && MODE == ACM_ACTIVE |=> MODE == ACM_STANDBY)
    else $error("to stby");
  a_regs_kept: assert property (MODE != ACM_OFF && $past(MODE) != ACM_OFF && !DATA_READY |->
    $stable(OUT_REGS))
    else $error("regs moved");
  a_ready_pulse: assert property (SAMPLE_TICK |=> DATA_READY ##1 !DATA_READY)
    else $error("ready");
endmodule
bind acm_mode_format acm_mode_format_chk u_chk (.CLK(CLK), .RSTN(RSTN), .CFG_WR_DONE(CFG_WR_DONE),
  .ACTIVE_BIT(ACTIVE_BIT), .MODE(MODE), .PWR(PWR), .SAMPLE_TICK(SAMPLE_TICK),
  .CLEAR_MARKED(CLEAR_MARKED), .OUT_REGS(OUT_REGS), .DATA_READY(DATA_READY));

//--- verification/acm_host_model.sv
// host model: writes the active bit and flags completion
// assumes the register write lands in one clock
`timescale 1ns/100ps
module acm_host_model (
  input wire logic clk,
  input wire logic wr_req,
  input wire logic wr_val,
  output logic active_bit = 1'b0,
  output logic wr_done = 1'b0
);
  // mode moves between standby and active only through this write
  always @(posedge clk) begin
    if (wr_req) active_bit <= wr_val;
    wr_done <= wr_req;
  end
endmodule

//--- verification/acm_mode_format_tb_top.sv
// bench: power modes, sample format, bus spike filter
// assumes host model drives the mode write
`timescale 1ns/100ps
module acm_mode_format_tb_top
  import acm_pkg::*;
;
  logic clk = 0, rstn = 0, pg = 0, scl = 1, sda = 1, wr_req = 0, wr_val = 0, st = 0, slp = 0;
  logic [1:0] rng = 0;
  acm_raw_t raw = '0;
  logic act, done, scl_f, sda_f, tick, clr, rdy;
  acm_mode_t mode;
  acm_pwr_t pwr;
  acm_out_t outr, keep;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  acm_host_model host (.clk(clk), .wr_req(wr_req), .wr_val(wr_val), .active_bit(act), .wr_done(done));
  acm_mode_format dut (.CLK(clk), .RSTN(rstn), .POWER_GOOD(pg), .SCL_PIN(scl), .SDA_PIN(sda),
    .ACTIVE_BIT(act), .CFG_WR_DONE(done), .RANGE_SEL(rng), .SELF_TEST_EN(st), .SLEEP_REQ(slp),
    .RAW_ACCEL(raw), .SCL_FILT(scl_f), .SDA_FILT(sda_f), .MODE(mode), .PWR(pwr), .SAMPLE_TICK(tick),
    .CLEAR_MARKED(clr), .OUT_REGS(outr), .DATA_READY(rdy));
  initial begin
    forever #4 clk = ~clk;
  end
  // generous: whole run needs about 9250 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic host_wr(input logic v);
    wr_val = v;
    wr_req = 1;
    step(1);
    wr_req = 0;
    step(1);
  endtask
  // tick must lead ready by one cycle, and the gap is the divider period
  task automatic wait_rdy(input int exp);
    int n;
    logic tk;
    n = 0;
    tk = 0;
    do begin
      tk = tick;
      step(1);
      n++;
    end while (rdy !== 1'b1 && n < exp + 100);
    chk(rdy, 1);
    chk(tk, 1);
    chk(n, exp);
  endtask
  function automatic logic [15:0] pk(input int v);
    return {v[11:0], 4'h0};
  endfunction
  task automatic t_power;
    pg = 1;
    step(8);
    chk(mode, ACM_STANDBY);
    chk(pwr, 4'hA);
  endtask
  task automatic t_format;
    int s, sh;
    host_wr(1);
    chk(mode, ACM_ACTIVE);
    chk(clr, 1);
    step(1);
    chk(clr, 0);
    raw = '{14'sd1024, -14'sd1024, 14'sd0};
    // code 3 names no range and must fall back to 2g
    for (int r = 0; r < 4; r++) begin
      s = r / 2;
      sh = r % 3;
      rng = r[1:0];
      st = s[0];
      wait_rdy(WAKE_DIV_CYC);
      chk(pwr, 4'hE);
      chk(outr, {pk((1024 + s * int'(STIM_X)) >>> sh), pk((-1024 + s * int'(STIM_Y)) >>> sh),
        pk((s * int'(STIM_Z)) >>> sh)});
    end
  endtask
  task automatic t_standby;
    logic seen;
    seen = 0;
    keep = outr;
    host_wr(0);
    chk(mode, ACM_STANDBY);
    repeat (1100) begin
      step(1);
      if (rdy === 1'b1) seen = 1;
    end
    chk(seen, 0);
    chk(outr, keep);
    host_wr(1);
    chk(clr, 1);
    chk(outr, keep);
  endtask
  task automatic t_sleep;
    slp = 1;
    // one more: the wait starts on the edge that entered active
    wait_rdy(SLEEP_DIV_CYC + 1);
    chk(mode, ACM_ACTIVE);
    chk(pwr, 4'hF);
    slp = 0;
  endtask
  // 6 cycles is 48 ns, inside the spike limit
  task automatic t_spike;
    {scl, sda} = 0;
    step(6);
    {scl, sda} = 2'b11;
    step(20);
    chk({scl_f, sda_f}, 2'b11);
    {scl, sda} = 0;
    step(20);
    chk({scl_f, sda_f}, 0);
    {scl, sda} = 2'b11;
    step(20);
  endtask
  task automatic t_off;
    pg = 0;
    step(10);
    chk(mode, ACM_OFF);
    chk(pwr, 0);
    scl = 0;
    step(20);
    chk(scl_f, 1);
  endtask
  initial begin
    step(16);
    rstn = 1;
    t_power();
    t_format();
    t_standby();
    t_sleep();
    t_spike();
    t_off();
    complete_run();
  end
endmodule
